// *** hw/dhtim_half.sv ***
`timescale 1ns/1ps
`default_nettype none
module dhtim_half (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Control
  input wire logic run,
  input wire logic joined,
  input wire dhtim_pkg::dht_mode_t mode,
  input wire dhtim_pkg::dht_cfg_t cfg,
  input wire logic load_wr,
  input wire logic edge_in,
  input wire logic borrow_in,
  // Results
  output logic [dhtim_pkg::HALF_W-1:0] count_r,
  output logic zero_now,
  output logic pwm_out,
  output dhtim_pkg::dht_evt_t evt
);
  logic [dhtim_pkg::PRE_W-1:0] pre_r;
  logic [dhtim_pkg::HALF_W-1:0] evt_cnt_r;
  logic tick;
  logic oneshot;
  assign oneshot = (mode == dhtim_pkg::DHT_ONE_SHOT);
  // Combined operation ignores the prescaler; the upper half counts borrows
  assign tick = joined ? borrow_in : (pre_r == dhtim_pkg::PRE_ZERO); // RQ16
  assign zero_now = (count_r == dhtim_pkg::HALF_ZERO);

  //////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pre_r <= dhtim_pkg::PRE_ZERO;
    end else if (ce) begin
      if (!run || joined || pre_r == dhtim_pkg::PRE_ZERO) begin
        pre_r <= cfg.pre; // RQ16
      end else begin
        pre_r <= pre_r - dhtim_pkg::PRE_ONE;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_r <= dhtim_pkg::HALF_RST;
    end else if (ce) begin
      if (load_wr) begin
        count_r <= cfg.load; // RQ10
      end else if (run && tick) begin
        if (zero_now) begin
          // One-shot holds at zero, periodic reloads
          if (!oneshot) begin
            count_r <= cfg.load; // RQ18
          end
        end else begin
          count_r <= count_r - dhtim_pkg::HALF_ONE;
        end
      end
    end
  end

  // Capture count: match value picks the event count that interrupts
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      evt_cnt_r <= dhtim_pkg::HALF_ZERO;
      evt <= '0;
    end else if (ce) begin
      evt <= '0;
      if (run && edge_in && (mode == dhtim_pkg::DHT_CAP_COUNT ||
          mode == dhtim_pkg::DHT_CAP_TIME)) begin
        evt.cap_event <= 1'b1;
        if (mode == dhtim_pkg::DHT_CAP_COUNT) begin
          if (evt_cnt_r + dhtim_pkg::HALF_ONE == cfg.match) begin
            evt.cap_match <= 1'b1; // RQ12
            evt_cnt_r <= dhtim_pkg::HALF_ZERO;
          end else begin
            evt_cnt_r <= evt_cnt_r + dhtim_pkg::HALF_ONE;
          end
        end
      end else if (!run) begin
        evt_cnt_r <= dhtim_pkg::HALF_ZERO;
      end
      if (run && tick && zero_now && !load_wr) begin
        evt.timeout <= 1'b1; // RQ19
      end
    end
  end

  // Edge-aligned PWM: high once count falls to match, low from reload
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pwm_out <= 1'b0;
    end else if (ce) begin
      pwm_out <= run && (mode == dhtim_pkg::DHT_PWM) &&
                 (count_r <= cfg.match); // RQ13
    end
  end
endmodule
`default_nettype wire

// *** hw/dhtim_pkg.sv ***
package dhtim_pkg;
  localparam int HALF_W = 16;
  localparam int FULL_W = 32;
  localparam int PRE_W = 8;
  localparam int IRQ_N = 7;
  // Interrupt source bit positions
  localparam int IRQ_B_CAP_EVENT = 0;
  localparam int IRQ_B_CAP_MATCH = 1;
  localparam int IRQ_B_TIMEOUT = 2;
  localparam int IRQ_RTC_MATCH = 3;
  localparam int IRQ_A_CAP_EVENT = 4;
  localparam int IRQ_A_CAP_MATCH = 5;
  localparam int IRQ_A_TIMEOUT = 6;
  localparam logic [HALF_W-1:0] HALF_RST = 16'hffff;
  localparam logic [HALF_W-1:0] HALF_ZERO = 16'h0000;
  localparam logic [HALF_W-1:0] HALF_ONE = 16'h0001;
  localparam logic [PRE_W-1:0] PRE_ZERO = 8'h00;
  localparam logic [PRE_W-1:0] PRE_ONE = 8'h01;
  localparam logic [IRQ_N-1:0] IRQ_NONE = 7'h00;
  // Timer select codes
  localparam logic [1:0] SEL_A = 2'h1;
  localparam logic [1:0] SEL_B = 2'h2;
  localparam logic [1:0] SEL_BOTH = 2'h3;
  typedef enum logic [2:0] {
    DHT_ONE_SHOT, DHT_PERIODIC, DHT_CAP_COUNT, DHT_CAP_TIME, DHT_PWM
  } dht_mode_t;
  typedef struct packed {
    logic [HALF_W-1:0] load;
    logic [HALF_W-1:0] match;
    logic [PRE_W-1:0] pre;
  } dht_cfg_t;
  typedef struct packed {
    logic cap_event;
    logic cap_match;
    logic timeout;
  } dht_evt_t;
endpackage

// *** hw/dhtim_top.sv ***
// Overview of operation
// RQ1: Software configures a half's mode before enabling it.
// RQ2: Enable and disable commands select first half, second half or both.
// RQ3: Clear bitmask drops each named pending flag.
// RQ4: Handlers clear pending flags early; clears may arrive late.
// RQ5: Only enabled sources reach the interrupt request.
// RQ6: Seven maskable sources: per half capture event, match, timeout; RTC.
// RQ7: Mask disable bitmask clears only the named enables.
// RQ8: Status readable raw or masked through a select input.
// RQ9: Each half's reload value reads back unchanged.
// RQ10: Writing reload while running loads the count at once.
// RQ11: In combined mode software uses only the first half's values.
// RQ12: Capture count raises match interrupt at the programmed event count.
// RQ13: PWM match value sets where output toggles each period.
// RQ14: Match value reads back exactly as written.
// RQ15: Prescaler holds 0 to 255 and reads back.
// RQ16: Prescaler divides only in 16-bit mode, ignored when combined.
// RQ17: Configuring mode disables the halves until enabled again.
// RQ18: One-shot stops at zero; periodic reloads and continues.
// RQ19: Timeout flag sets when a counter reaches zero.
// RQ20: Request is OR of pending flags ANDed with enables.
`timescale 1ns/1ps
`default_nettype none
module dhtim_top (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic CE,
  // Mode configuration
  input wire logic CFG_WR,
  input wire logic CFG_JOINED,
  input wire dhtim_pkg::dht_mode_t CFG_MODE_A,
  input wire dhtim_pkg::dht_mode_t CFG_MODE_B,
  // Enable commands
  input wire logic EN_WR,
  input wire logic DIS_WR,
  input wire logic [1:0] TIMER_SEL,
  // Value writes
  input wire logic LOAD_WR,
  input wire logic MATCH_WR,
  input wire logic PRE_WR,
  input wire logic [dhtim_pkg::FULL_W-1:0] WR_VALUE,
  input wire logic [dhtim_pkg::PRE_W-1:0] PRE_VALUE,
  // Interrupt control
  input wire logic IRQ_EN_WR,
  input wire logic IRQ_DIS_WR,
  input wire logic IRQ_CLR_WR,
  input wire logic [dhtim_pkg::IRQ_N-1:0] IRQ_SOURCE_BITMASK,
  input wire logic STATUS_MASKED_SELECT,
  input wire logic RTC_MATCH_EVT,
  // Capture pins
  input wire logic CAP_A_PIN,
  input wire logic CAP_B_PIN,
  // Read back
  output logic [dhtim_pkg::FULL_W-1:0] LOAD_A_RD,
  output logic [dhtim_pkg::HALF_W-1:0] LOAD_B_RD,
  output logic [dhtim_pkg::FULL_W-1:0] MATCH_A_RD,
  output logic [dhtim_pkg::HALF_W-1:0] MATCH_B_RD,
  output logic [dhtim_pkg::PRE_W-1:0] PRE_A_RD,
  output logic [dhtim_pkg::PRE_W-1:0] PRE_B_RD,
  output logic [dhtim_pkg::FULL_W-1:0] VALUE_A_RD,
  output logic [dhtim_pkg::HALF_W-1:0] VALUE_B_RD,
  output logic [1:0] RUN_STATE,
  output logic [dhtim_pkg::IRQ_N-1:0] IRQ_STATUS,
  output logic [dhtim_pkg::IRQ_N-1:0] IRQ_ENABLE,
  // Outputs
  output logic PWM_A,
  output logic PWM_B,
  output logic IRQ
);
  dhtim_pkg::dht_cfg_t cfg_a_r, cfg_b_r;
  dhtim_pkg::dht_mode_t mode_a_r, mode_b_r;
  dhtim_pkg::dht_evt_t evt_a, evt_b;
  logic joined_r;
  logic run_a_r, run_b_r;
  logic [dhtim_pkg::IRQ_N-1:0] pend_r, mask_r, set_vec;
  logic [2:0] sync_a_r, sync_b_r;
  logic zero_a, zero_b, pwm_a, pwm_b;
  logic [dhtim_pkg::HALF_W-1:0] cnt_a, cnt_b;
  logic sel_a, sel_b, load_a, load_b;
  logic wrap_a;
  dhtim_pkg::dht_cfg_t cfg_a_in, cfg_b_in;

  function automatic logic hits(input logic [1:0] sel, input logic bit_n);
    hits = bit_n ? sel[1] : sel[0];
  endfunction

  // Combined mode routes writes to both halves through the first half
  assign sel_a = hits(TIMER_SEL, 1'b0) | joined_r; // RQ2 RQ11
  assign sel_b = hits(TIMER_SEL, 1'b1) | joined_r; // RQ2 RQ11
  assign load_a = LOAD_WR && sel_a && run_a_r; // RQ10
  assign load_b = LOAD_WR && sel_b && run_b_r; // RQ10
  // Lower half wraps, not reloads, while the upper half still counts
  assign wrap_a = joined_r && run_a_r && zero_a && !zero_b; // RQ11

  // Running reload must reach the count, not the stale stored value
  always_comb begin
    cfg_a_in = cfg_a_r;
    cfg_b_in = cfg_b_r;
    if (joined_r) begin
      cfg_a_in.pre = dhtim_pkg::PRE_ZERO; // RQ16
    end
    if (wrap_a) begin
      cfg_a_in.load = dhtim_pkg::HALF_RST;
    end
    if (LOAD_WR && sel_a) begin
      cfg_a_in.load = WR_VALUE[dhtim_pkg::HALF_W-1:0]; // RQ10
    end
    if (LOAD_WR && sel_b) begin
      cfg_b_in.load = joined_r ? WR_VALUE[dhtim_pkg::FULL_W-1:
        dhtim_pkg::HALF_W] : WR_VALUE[dhtim_pkg::HALF_W-1:0]; // RQ10
    end
  end

  //////////////////////////////////////////////////////////////////////////
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      joined_r <= 1'b0;
      mode_a_r <= dhtim_pkg::DHT_ONE_SHOT;
      mode_b_r <= dhtim_pkg::DHT_ONE_SHOT;
    end else if (CE && CFG_WR) begin
      joined_r <= CFG_JOINED;
      mode_a_r <= CFG_MODE_A;
      mode_b_r <= CFG_JOINED ? CFG_MODE_A : CFG_MODE_B;
    end
  end

  // Configuration wins over a same-cycle enable so the halves stay off
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      run_a_r <= 1'b0;
      run_b_r <= 1'b0;
    end else if (CE) begin
      if (CFG_WR) begin
        run_a_r <= 1'b0; // RQ17
        run_b_r <= 1'b0; // RQ17
      end else if (EN_WR) begin
        run_a_r <= run_a_r | sel_a; // RQ2
        run_b_r <= run_b_r | sel_b; // RQ2
      end else if (DIS_WR) begin
        run_a_r <= run_a_r & ~sel_a; // RQ2
        run_b_r <= run_b_r & ~sel_b; // RQ2
      end
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      cfg_a_r <= '0;
      cfg_b_r <= '0;
    end else if (CE) begin
      if (LOAD_WR && sel_a) begin
        cfg_a_r.load <= WR_VALUE[dhtim_pkg::HALF_W-1:0]; // RQ9
      end
      if (LOAD_WR && sel_b) begin
        cfg_b_r.load <= joined_r ? WR_VALUE[dhtim_pkg::FULL_W-1:
          dhtim_pkg::HALF_W] : WR_VALUE[dhtim_pkg::HALF_W-1:0]; // RQ9
      end
      if (MATCH_WR && sel_a) begin
        cfg_a_r.match <= WR_VALUE[dhtim_pkg::HALF_W-1:0]; // RQ14
      end
      if (MATCH_WR && sel_b) begin
        cfg_b_r.match <= joined_r ? WR_VALUE[dhtim_pkg::FULL_W-1:
          dhtim_pkg::HALF_W] : WR_VALUE[dhtim_pkg::HALF_W-1:0]; // RQ14
      end
      // Eight-bit field cannot hold anything beyond 255
      if (PRE_WR && hits(TIMER_SEL, 1'b0)) begin
        cfg_a_r.pre <= PRE_VALUE; // RQ15
      end
      if (PRE_WR && hits(TIMER_SEL, 1'b1)) begin
        cfg_b_r.pre <= PRE_VALUE; // RQ15
      end
    end
  end

  // Capture pins: two-stage sync, edge taken from stages two and three
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      sync_a_r <= 3'h0;
      sync_b_r <= 3'h0;
    end else if (CE) begin
      sync_a_r <= {sync_a_r[1:0], CAP_A_PIN};
      sync_b_r <= {sync_b_r[1:0], CAP_B_PIN};
    end
  end

  //////////////////////////////////////////////////////////////////////////
  dhtim_half u_half_a (
    .clk(CLK_SYS),
    .rst(RST),
    .ce(CE),
    .run(run_a_r),
    .joined(1'b0),
    .mode(mode_a_r),
    .cfg(cfg_a_in),
    .load_wr(load_a | wrap_a),
    .edge_in(sync_a_r[2] ^ sync_a_r[1]),
    .borrow_in(1'b0),
    .count_r(cnt_a),
    .zero_now(zero_a),
    .pwm_out(pwm_a),
    .evt(evt_a)
  );

  // Upper half steps on each lower-half wrap when joined
  dhtim_half u_half_b (
    .clk(CLK_SYS),
    .rst(RST),
    .ce(CE),
    .run(joined_r ? run_a_r : run_b_r),
    .joined(joined_r),
    .mode(mode_b_r),
    .cfg(cfg_b_in),
    .load_wr(joined_r ? load_a : load_b),
    .edge_in(sync_b_r[2] ^ sync_b_r[1]),
    .borrow_in(zero_a && !(zero_b && mode_a_r == dhtim_pkg::DHT_ONE_SHOT)),
    .count_r(cnt_b),
    .zero_now(zero_b),
    .pwm_out(pwm_b),
    .evt(evt_b)
  );

  //////////////////////////////////////////////////////////////////////////
  always_comb begin
    set_vec = dhtim_pkg::IRQ_NONE;
    set_vec[dhtim_pkg::IRQ_A_CAP_EVENT] = evt_a.cap_event; // RQ6
    set_vec[dhtim_pkg::IRQ_A_CAP_MATCH] = evt_a.cap_match;
    set_vec[dhtim_pkg::IRQ_B_CAP_EVENT] = evt_b.cap_event && !joined_r;
    set_vec[dhtim_pkg::IRQ_B_CAP_MATCH] = evt_b.cap_match && !joined_r;
    set_vec[dhtim_pkg::IRQ_RTC_MATCH] = RTC_MATCH_EVT;
    if (joined_r) begin
      // Lower half times out only when no wrap was taken: whole count zero
      set_vec[dhtim_pkg::IRQ_A_TIMEOUT] = evt_a.timeout; // RQ19
    end else begin
      set_vec[dhtim_pkg::IRQ_A_TIMEOUT] = evt_a.timeout; // RQ19
      set_vec[dhtim_pkg::IRQ_B_TIMEOUT] = evt_b.timeout; // RQ19
    end
  end

  // New events win over a same-cycle clear
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      pend_r <= dhtim_pkg::IRQ_NONE;
    end else if (CE) begin
      pend_r <= (pend_r & ~(IRQ_CLR_WR ? IRQ_SOURCE_BITMASK
        : dhtim_pkg::IRQ_NONE)) | set_vec; // RQ3
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      mask_r <= dhtim_pkg::IRQ_NONE;
    end else if (CE) begin
      if (IRQ_EN_WR) begin
        mask_r <= mask_r | IRQ_SOURCE_BITMASK; // RQ6
      end else if (IRQ_DIS_WR) begin
        mask_r <= mask_r & ~IRQ_SOURCE_BITMASK; // RQ7
      end
    end
  end

  assign IRQ = |(pend_r & mask_r); // RQ5 RQ20
  assign IRQ_STATUS = STATUS_MASKED_SELECT ? (pend_r & mask_r) : pend_r; // RQ8
  assign IRQ_ENABLE = mask_r;
  assign LOAD_A_RD = joined_r ? {cfg_b_r.load, cfg_a_r.load}
    : {dhtim_pkg::HALF_ZERO, cfg_a_r.load};
  assign LOAD_B_RD = cfg_b_r.load;
  assign MATCH_A_RD = joined_r ? {cfg_b_r.match, cfg_a_r.match}
    : {dhtim_pkg::HALF_ZERO, cfg_a_r.match};
  assign MATCH_B_RD = cfg_b_r.match;
  assign PRE_A_RD = cfg_a_r.pre;
  assign PRE_B_RD = cfg_b_r.pre;
  assign VALUE_A_RD = joined_r ? {cnt_b, cnt_a} : {dhtim_pkg::HALF_ZERO, cnt_a};
  assign VALUE_B_RD = cnt_b;
  assign RUN_STATE = {run_b_r, run_a_r};
  assign PWM_A = pwm_a;
  assign PWM_B = pwm_b && !joined_r;
endmodule
`default_nettype wire

// *** testbench/dhtim_top_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
module dhtim_top_properties (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic CE,
  // Commands
  input wire logic CFG_WR,
  input wire logic EN_WR,
  input wire logic DIS_WR,
  input wire logic [1:0] TIMER_SEL,
  input wire logic LOAD_WR,
  input wire logic [dhtim_pkg::FULL_W-1:0] WR_VALUE,
  input wire logic IRQ_EN_WR,
  input wire logic IRQ_DIS_WR,
  input wire logic IRQ_CLR_WR,
  input wire logic [dhtim_pkg::IRQ_N-1:0] IRQ_SOURCE_BITMASK,
  input wire logic STATUS_MASKED_SELECT,
  input wire logic RTC_MATCH_EVT,
  // Observed
  input wire logic [dhtim_pkg::FULL_W-1:0] VALUE_A_RD,
  input wire logic [1:0] RUN_STATE,
  input wire logic [dhtim_pkg::IRQ_N-1:0] IRQ_STATUS,
  input wire logic [dhtim_pkg::IRQ_N-1:0] IRQ_ENABLE,
  input wire logic PWM_B,
  input wire logic IRQ
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  ////////////////////////////////////////
  AST_EN_SEL: assert property (
    CE && EN_WR && !CFG_WR |=>
    (RUN_STATE & $past(TIMER_SEL)) == $past(TIMER_SEL))
    else $error("enable missed a selected half");
  AST_DIS_SEL: assert property (
    CE && DIS_WR && !EN_WR && !CFG_WR |=>
    (RUN_STATE & $past(TIMER_SEL)) == 2'h0)
    else $error("disable left a selected half running");
  AST_CFG_STOP: assert property (
    CE && CFG_WR |=> RUN_STATE == 2'h0)
    else $error("configuration did not stop the halves");
  AST_IRQ_EN: assert property (
    CE && IRQ_EN_WR |=>
    IRQ_ENABLE == ($past(IRQ_ENABLE) | $past(IRQ_SOURCE_BITMASK)))
    else $error("source enable wrong");
  AST_IRQ_DIS: assert property (
    CE && IRQ_DIS_WR && !IRQ_EN_WR |=>
    IRQ_ENABLE == ($past(IRQ_ENABLE) & ~$past(IRQ_SOURCE_BITMASK)))
    else $error("source disable touched other enables");
  AST_RTC_SET: assert property (
    CE && RTC_MATCH_EVT ##1 !STATUS_MASKED_SELECT |-> IRQ_STATUS[3])
    else $error("rtc match not pending");
  AST_CLR: assert property (
    CE && IRQ_CLR_WR && IRQ_SOURCE_BITMASK[3] && !RTC_MATCH_EVT
    ##1 !STATUS_MASKED_SELECT |-> !IRQ_STATUS[3])
    else $error("cleared source still pending");
  AST_IRQ_OR: assert property (
    IRQ == |(IRQ_STATUS & IRQ_ENABLE))
    else $error("request not the or of enabled pending flags");
  AST_MASKED: assert property (
    STATUS_MASKED_SELECT |-> (IRQ_STATUS & ~IRQ_ENABLE) == 7'h00)
    else $error("masked status shows a disabled source");
  AST_LOAD_RUN: assert property (
    CE && LOAD_WR && TIMER_SEL[0] && RUN_STATE[0] && !CFG_WR && !DIS_WR |=>
    VALUE_A_RD[15:0] == $past(WR_VALUE[15:0]))
    else $error("running reload not taken at once");
  cover property (IRQ);
  cover property (PWM_B);
  cover property (RUN_STATE == 2'h3);
endmodule
bind dhtim_top dhtim_top_properties i_dhtim_top_properties (.CLK_SYS, .RST,
  .CE, .CFG_WR, .EN_WR, .DIS_WR, .TIMER_SEL, .LOAD_WR, .WR_VALUE, .IRQ_EN_WR,
  .IRQ_DIS_WR, .IRQ_CLR_WR, .IRQ_SOURCE_BITMASK, .STATUS_MASKED_SELECT,
  .RTC_MATCH_EVT, .VALUE_A_RD, .RUN_STATE, .IRQ_STATUS, .IRQ_ENABLE, .PWM_B,
  .IRQ);
`default_nettype wire

// *** testbench/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk, rst, ce, jn, msk, pa, pb, pwa, pwb, irq;
  dhtim_pkg::dht_mode_t ma, mb;
  logic [9:0] stb;
  logic [1:0] sel, run;
  logic [31:0] v, lda, mta, vla;
  logic [15:0] ldb, mtb, vlb;
  logic [7:0] pra, prb;
  logic [6:0] st, ena;
  int err_total, n_checks, k, hi;
  ////////////////////////////////////////
  dhtim_top i_dhtim_top (
    .CLK_SYS(clk), .RST(rst), .CE(ce), .CFG_WR(stb[0]), .CFG_JOINED(jn),
    .CFG_MODE_A(ma), .CFG_MODE_B(mb), .EN_WR(stb[1]), .DIS_WR(stb[2]),
    .TIMER_SEL(sel), .LOAD_WR(stb[3]), .MATCH_WR(stb[4]), .PRE_WR(stb[5]),
    .WR_VALUE(v), .PRE_VALUE(v[7:0]), .IRQ_EN_WR(stb[6]),
    .IRQ_DIS_WR(stb[7]), .IRQ_CLR_WR(stb[8]), .IRQ_SOURCE_BITMASK(v[6:0]),
    .STATUS_MASKED_SELECT(msk), .RTC_MATCH_EVT(stb[9]), .CAP_A_PIN(pa),
    .CAP_B_PIN(pb), .LOAD_A_RD(lda), .LOAD_B_RD(ldb), .MATCH_A_RD(mta),
    .MATCH_B_RD(mtb), .PRE_A_RD(pra), .PRE_B_RD(prb), .VALUE_A_RD(vla),
    .VALUE_B_RD(vlb), .RUN_STATE(run), .IRQ_STATUS(st), .IRQ_ENABLE(ena),
    .PWM_A(pwa), .PWM_B(pwb), .IRQ(irq));
  ////////////////////////////////////////
  task automatic tick(input int n);
    stb = 10'h000;
    repeat (n) @(posedge clk);
    #1;
  endtask
  // One strobe per call; it stands until the next call or wait
  task automatic cmd(input int s, input logic [1:0] t, input logic [31:0] d);
    stb = 10'h001 << s;
    sel = t;
    v = d;
    @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    #20000;
    err_total++;
    wrap_up();
  end
  initial begin
    {rst, ce, jn, msk, pa, pb} = 6'h30;
    {stb, sel, v} = 44'h0;
    ma = dhtim_pkg::DHT_ONE_SHOT;
    mb = dhtim_pkg::DHT_PERIODIC;
    repeat (10) @(posedge clk);
    #1;
    rst = 1'b0;
    chk(run, 32'h0);
    chk(st, 32'h0);
    cmd(0, 2'h0, 32'h0);
    cmd(3, dhtim_pkg::SEL_BOTH, 32'h0000a5c3);
    chk(lda, 32'h0000a5c3);
    chk(ldb, 32'ha5c3);
    cmd(4, dhtim_pkg::SEL_B, 32'h00001234);
    chk(mtb, 32'h1234);
    chk(mta, 32'h0);
    cmd(5, dhtim_pkg::SEL_A, 32'h000000ff);
    chk(pra, 32'hff);
    chk(prb, 32'h0);
    for (k = 1; k < 4; k++) begin
      cmd(1, k[1:0], 32'h0);
      chk(run, k);
      cmd(2, k[1:0], 32'h0);
      chk(run, 32'h0);
    end
    cmd(1, dhtim_pkg::SEL_BOTH, 32'h0);
    cmd(0, 2'h0, 32'h0);
    chk(run, 32'h0);
    cmd(6, 2'h0, 32'h7f);
    chk(ena, 32'h7f);
    cmd(7, 2'h0, 32'h55);
    chk(ena, 32'h2a);
    cmd(9, 2'h0, 32'h0);
    tick(1);
    chk(st, 32'h08);
    chk(irq, 32'h1);
    cmd(7, 2'h0, 32'h08);
    chk(irq, 32'h0);
    chk(st, 32'h08);
    msk = 1'b1;
    tick(1);
    chk(st, 32'h0);
    msk = 1'b0;
    cmd(6, 2'h0, 32'h08);
    chk(irq, 32'h1);
    cmd(8, 2'h0, 32'h08);
    chk(st, 32'h0);
    chk(irq, 32'h0);
    // One-shot half A with a running reload
    cmd(5, dhtim_pkg::SEL_BOTH, 32'h0);
    cmd(1, dhtim_pkg::SEL_A, 32'h0);
    cmd(3, dhtim_pkg::SEL_A, 32'h5);
    chk(vla, 32'h5);
    tick(5);
    chk(vla, 32'h0);
    chk(st, 32'h0);
    tick(2);
    chk(st, 32'h40);
    tick(3);
    chk(vla, 32'h0);
    // Periodic half B, then prescaled
    cmd(2, dhtim_pkg::SEL_A, 32'h0);
    tick(1);
    cmd(8, 2'h0, 32'h7f);
    cmd(1, dhtim_pkg::SEL_B, 32'h0);
    cmd(3, dhtim_pkg::SEL_B, 32'h3);
    tick(4);
    chk(vlb, 32'h3);
    tick(1);
    chk(st, 32'h04);
    cmd(5, dhtim_pkg::SEL_B, 32'h1);
    cmd(3, dhtim_pkg::SEL_B, 32'h8);
    tick(6);
    chk(vlb >= 16'h5 && vlb <= 16'h6, 32'h1);
    // Joined: prescale ignored, borrow into the upper half
    jn = 1'b1;
    ma = dhtim_pkg::DHT_PERIODIC;
    cmd(0, 2'h0, 32'h0);
    cmd(5, dhtim_pkg::SEL_BOTH, 32'h3);
    cmd(1, dhtim_pkg::SEL_A, 32'h0);
    chk(run, 32'h3);
    cmd(3, dhtim_pkg::SEL_A, 32'h00010002);
    chk(vla, 32'h00010002);
    tick(3);
    chk(vla, 32'h0000ffff);
    chk(lda, 32'h00010002);
    // Edge count capture on half A
    jn = 1'b0;
    ma = dhtim_pkg::DHT_CAP_COUNT;
    mb = dhtim_pkg::DHT_PWM;
    cmd(0, 2'h0, 32'h0);
    cmd(8, 2'h0, 32'h7f);
    cmd(4, dhtim_pkg::SEL_A, 32'h2);
    cmd(1, dhtim_pkg::SEL_A, 32'h0);
    for (k = 0; k < 2; k++) begin
      chk(st[5], 32'h0);
      pa = ~pa;
      tick(8);
    end
    chk(st[5:4], 32'h3);
    // Time capture: event flag only, never a match
    ma = dhtim_pkg::DHT_CAP_TIME;
    cmd(0, 2'h0, 32'h0);
    cmd(8, 2'h0, 32'h7f);
    cmd(1, dhtim_pkg::SEL_A, 32'h0);
    pa = ~pa;
    tick(8);
    chk(st[5:4], 32'h1);
    // PWM on half B: period 8, high while count <= 3
    cmd(5, dhtim_pkg::SEL_B, 32'h0);
    cmd(4, dhtim_pkg::SEL_B, 32'h3);
    cmd(1, dhtim_pkg::SEL_B, 32'h0);
    cmd(3, dhtim_pkg::SEL_B, 32'h7);
    tick(2);
    hi = 0;
    repeat (16) begin
      hi += (pwb === 1'b1);
      tick(1);
    end
    chk(hi, 32'h8);
    chk(pwa, 32'h0);
    wrap_up();
  end
endmodule
`default_nettype wire
